/* hdl/page_translation.sv */
// Purpose: two-level paging unit with translation cache and table walker
// Assumes: memory bus holds a request until ack, one word per ack
// Notes:   walks hold the bus lock from the first table read to the end
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Translate through a 4 KB directory then 4 KB page table.
// - Directory index is linear address bits 31 to 22.
// - Table index is linear address bits 21 to 12.
// - Entry bits 31 to 12 give the next base, low 12 bits zero.
// - Only 24 address bits leave; bits 31 to 24 are dropped.
// - Fault address register keeps the linear address of the last fault.
// - Directory base keeps 24 bits, low 12 always zero.
// - Directory base write or task switch flush empties the cache.
// - Entries with present clear are unused; other bits ignored.
// - Accessed bit set in both entries before the access.
// - Dirty bit set in table entry before a write.
// - Flag updates use a locked read-modify-write.
// - Entry bits 11 to 9 belong to software and are ignored.
// - Page protection checks apply to user level only.
// - Directory bits cover a whole table, table bits one page.
// - Effective permission is the stricter of both entries.
// - A 32-entry four-way cache holds translations, filled by hardware.
// - Address bits 14 to 12 pick one of 8 sets; bits 31 to 15 are compared against its four ways only.
// - Absent directory or table entry raises a page fault.
// - Protection violation raises a page fault and records the address.
// - Paging acts only while control bit 31 is set; else pass-through.
module page_translation
  import paging_pkg::*;
#(
  parameter int TLB_ENTRIES_P = paging_pkg::TLB_ENTRIES,
  parameter int TLB_WAYS_P    = paging_pkg::TLB_WAYS
) (
  // clock, reset, enable
  input  wire logic                          clk_i,
  input  wire logic                          arst_n_i,
  input  wire logic                          ce_i,
  // segmentation side
  input  wire logic                          req_valid_i,
  input  wire logic [paging_pkg::LA_W-1:0]   req_lin_addr_i,
  input  wire logic                          req_write_i,
  input  wire logic                          req_user_i,
  output logic                               req_ready_o,
  output logic                               done_o,
  output logic [paging_pkg::PA_W-1:0]        phys_addr_o,
  output logic                               fault_o,
  output logic [2:0]                         fault_code_o,
  // control registers
  input  wire logic [paging_pkg::LA_W-1:0]   machine_control_reg_i,
  input  wire logic                          cr_write_i,
  input  wire logic                          cr_sel_dir_i,
  input  wire logic [paging_pkg::LA_W-1:0]   cr_wdata_i,
  input  wire logic                          task_switch_flush_i,
  output logic [paging_pkg::LA_W-1:0]        fault_linear_address_reg_o,
  output logic [paging_pkg::LA_W-1:0]        directory_base_reg_o,
  // memory bus
  output logic                               mem_req_o,
  output logic [paging_pkg::PA_W-1:0]        mem_addr_o,
  output logic                               mem_we_o,
  output logic                               mem_lock_o,
  output logic [paging_pkg::LA_W-1:0]        mem_wdata_o,
  input  wire logic [paging_pkg::LA_W-1:0]   mem_rdata_i,
  input  wire logic                          mem_ack_i
);
  import paging_pkg::*;

  if (TLB_ENTRIES_P % TLB_WAYS_P != 0 || TLB_WAYS_P < 2) begin : g_chk
    $error("page_translation: bad cache geometry");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic prot_fail(input logic usr, input logic wr,
                                     input logic us, input logic rw);
    prot_fail = usr && (!us || (wr && !rw));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  walk_state_e             state_ff, nxt_state;
  logic [LA_W-1:0]         lin_ff, nxt_lin;
  logic                    wr_ff, nxt_wr;
  logic                    usr_ff, nxt_usr;
  logic [LA_W-1:0]         pde_ff, nxt_pde;
  logic [LA_W-1:0]         pte_ff, nxt_pte;
  logic                    ready_ff, nxt_ready;
  logic                    done_ff, nxt_done;
  logic [PA_W-1:0]         phys_ff, nxt_phys;
  logic                    fault_ff, nxt_fault;
  logic [2:0]              fcode_ff, nxt_fcode;
  logic [LA_W-1:0]         cr2_ff, nxt_cr2;
  logic [LA_W-1:0]         cr3_ff, nxt_cr3;
  logic                    mreq_ff, nxt_mreq;
  logic [PA_W-1:0]         maddr_ff, nxt_maddr;
  logic                    mwe_ff, nxt_mwe;
  logic                    mlock_ff, nxt_mlock;
  logic [LA_W-1:0]         mwdata_ff, nxt_mwdata;

  logic                    tlb_hit;
  logic [FRAME_W-1:0]      tlb_frame;
  logic                    tlb_us;
  logic                    tlb_rw;
  logic                    tlb_dirty;
  logic                    tlb_fill;
  logic                    tlb_flush;
  logic                    paging_on;
  logic                    eff_us;
  logic                    eff_rw;
  logic [LA_W-1:0]         pte_upd;

  assign paging_on = machine_control_reg_i[PAGING_BIT];
  // flush on base write or task switch
  assign tlb_flush = (cr_write_i && cr_sel_dir_i) || task_switch_flush_i;
  // stricter of directory and table bits
  assign eff_us = pde_ff[US_BIT] & mem_rdata_i[US_BIT];
  assign eff_rw = pde_ff[RW_BIT] & mem_rdata_i[RW_BIT];
  assign pte_upd = mem_rdata_i | (LA_W'(1) << ACC_BIT)
                 | (LA_W'(wr_ff) << DIRTY_BIT);

  translation_cache #(
    .ENTRIES (TLB_ENTRIES_P),
    .WAYS    (TLB_WAYS_P)
  ) u_cache (
    .clk_i        (clk_i),
    .rst_n_i      (rst_n),
    .ce_i         (ce_i),
    .vpn_i        (lin_ff[LA_W-1:OFS_W]),
    .hit_o        (tlb_hit),
    .hit_frame_o  (tlb_frame),
    .hit_us_o     (tlb_us),
    .hit_rw_o     (tlb_rw),
    .hit_dirty_o  (tlb_dirty),
    .fill_i       (tlb_fill),
    .fill_frame_i (pte_ff[PA_W-1:OFS_W]),
    .fill_us_i    (pde_ff[US_BIT] & pte_ff[US_BIT]),
    .fill_rw_i    (pde_ff[RW_BIT] & pte_ff[RW_BIT]),
    .fill_dirty_i (pte_ff[DIRTY_BIT]),
    .flush_i      (tlb_flush)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_state  = state_ff;
    nxt_lin    = lin_ff;
    nxt_wr     = wr_ff;
    nxt_usr    = usr_ff;
    nxt_pde    = pde_ff;
    nxt_pte    = pte_ff;
    nxt_ready  = ready_ff;
    nxt_done   = 1'b0;
    nxt_phys   = phys_ff;
    nxt_fault  = 1'b0;
    nxt_fcode  = fcode_ff;
    nxt_mreq   = mreq_ff;
    nxt_maddr  = maddr_ff;
    nxt_mwe    = mwe_ff;
    nxt_mlock  = mlock_ff;
    nxt_mwdata = mwdata_ff;
    tlb_fill   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        nxt_ready = 1'b1;
        if (req_valid_i && ready_ff) begin
          nxt_lin   = req_lin_addr_i;
          nxt_wr    = req_write_i;
          nxt_usr   = req_user_i;
          nxt_ready = 1'b0;
          nxt_state = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (!paging_on) begin
          nxt_phys  = lin_ff[PA_W-1:0];
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else if (tlb_hit && !(wr_ff && !tlb_dirty)) begin
          if (prot_fail(usr_ff, wr_ff, tlb_us, tlb_rw)) begin
            nxt_fault = 1'b1;
            nxt_fcode = {usr_ff, wr_ff, 1'b1};
          end else begin
            nxt_phys = {tlb_frame, lin_ff[OFS_W-1:0]};
            nxt_done = 1'b1;
          end
          nxt_state = ST_IDLE;
        end else begin
          nxt_maddr = {cr3_ff[PA_W-1:OFS_W],
                       lin_ff[LA_W-1:DIR_IDX_LSB], 2'b00};
          nxt_mreq  = 1'b1;
          nxt_mwe   = 1'b0;
          nxt_mlock = 1'b1;
          nxt_state = ST_DIR_RD;
        end
      end
      ST_DIR_RD: begin
        if (mem_ack_i) begin
          nxt_pde = mem_rdata_i;
          if (!mem_rdata_i[PRESENT_BIT]) begin
            nxt_fault = 1'b1;
            nxt_fcode = {usr_ff, wr_ff, 1'b0};
            nxt_mreq  = 1'b0;
            nxt_mlock = 1'b0;
            nxt_state = ST_IDLE;
          end else if (!mem_rdata_i[ACC_BIT]) begin
            nxt_mwe    = 1'b1;
            nxt_mwdata = mem_rdata_i | (LA_W'(1) << ACC_BIT);
            nxt_state  = ST_DIR_WR;
          end else begin
            nxt_maddr = {mem_rdata_i[PA_W-1:OFS_W],
                         lin_ff[DIR_IDX_LSB-1:TBL_IDX_LSB], 2'b00};
            nxt_state = ST_TBL_RD;
          end
        end
      end
      ST_DIR_WR: begin
        if (mem_ack_i) begin
          nxt_maddr = {pde_ff[PA_W-1:OFS_W],
                       lin_ff[DIR_IDX_LSB-1:TBL_IDX_LSB], 2'b00};
          nxt_mwe   = 1'b0;
          nxt_state = ST_TBL_RD;
        end
      end
      ST_TBL_RD: begin
        if (mem_ack_i) begin
          nxt_pte  = pte_upd;
          nxt_mreq = 1'b0;
          if (!mem_rdata_i[PRESENT_BIT]) begin
            nxt_fault = 1'b1;
            nxt_fcode = {usr_ff, wr_ff, 1'b0};
            nxt_mlock = 1'b0;
            nxt_state = ST_IDLE;
          end else if (prot_fail(usr_ff, wr_ff, eff_us, eff_rw)) begin
            nxt_fault = 1'b1;
            nxt_fcode = {usr_ff, wr_ff, 1'b1};
            nxt_mlock = 1'b0;
            nxt_state = ST_IDLE;
          end else if (pte_upd != mem_rdata_i) begin
            nxt_mreq   = 1'b1;
            nxt_mwe    = 1'b1;
            nxt_mwdata = pte_upd;
            nxt_state  = ST_TBL_WR;
          end else begin
            nxt_mlock = 1'b0;
            nxt_state = ST_FILL;
          end
        end
      end
      ST_TBL_WR: begin
        if (mem_ack_i) begin
          nxt_mreq  = 1'b0;
          nxt_mwe   = 1'b0;
          nxt_mlock = 1'b0;
          nxt_state = ST_FILL;
        end
      end
      ST_FILL: begin
        tlb_fill  = 1'b1;
        nxt_phys  = {pte_ff[PA_W-1:OFS_W], lin_ff[OFS_W-1:0]};
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_mreq  = 1'b0;
        nxt_mlock = 1'b0;
      end
    endcase
    nxt_cr2 = cr2_ff;
    if (nxt_fault) begin
      nxt_cr2 = lin_ff;
    end else if (cr_write_i && !cr_sel_dir_i) begin
      nxt_cr2 = cr_wdata_i;
    end
    // base kept page aligned, 24 bits
    nxt_cr3 = cr3_ff;
    if (cr_write_i && cr_sel_dir_i) begin
      nxt_cr3 = {{(LA_W-PA_W){1'b0}}, cr_wdata_i[PA_W-1:OFS_W],
                 {OFS_W{1'b0}}};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_IDLE;
      lin_ff    <= '0;
      wr_ff     <= 1'b0;
      usr_ff    <= 1'b0;
      pde_ff    <= '0;
      pte_ff    <= '0;
      ready_ff  <= 1'b0;
      done_ff   <= 1'b0;
      phys_ff   <= '0;
      fault_ff  <= 1'b0;
      fcode_ff  <= 3'h0;
      cr2_ff    <= FAULT_ADDR_RST;
      cr3_ff    <= DIR_BASE_RST;
      mreq_ff   <= 1'b0;
      maddr_ff  <= '0;
      mwe_ff    <= 1'b0;
      mlock_ff  <= 1'b0;
      mwdata_ff <= '0;
    end else if (ce_i) begin
      state_ff  <= nxt_state;
      lin_ff    <= nxt_lin;
      wr_ff     <= nxt_wr;
      usr_ff    <= nxt_usr;
      pde_ff    <= nxt_pde;
      pte_ff    <= nxt_pte;
      ready_ff  <= nxt_ready;
      done_ff   <= nxt_done;
      phys_ff   <= nxt_phys;
      fault_ff  <= nxt_fault;
      fcode_ff  <= nxt_fcode;
      cr2_ff    <= nxt_cr2;
      cr3_ff    <= nxt_cr3;
      mreq_ff   <= nxt_mreq;
      maddr_ff  <= nxt_maddr;
      mwe_ff    <= nxt_mwe;
      mlock_ff  <= nxt_mlock;
      mwdata_ff <= nxt_mwdata;
    end
  end

  assign req_ready_o                = ready_ff;
  assign done_o                     = done_ff;
  assign phys_addr_o                = phys_ff;
  assign fault_o                    = fault_ff;
  assign fault_code_o               = fcode_ff;
  assign fault_linear_address_reg_o = cr2_ff;
  assign directory_base_reg_o       = cr3_ff;
  assign mem_req_o                  = mreq_ff;
  assign mem_addr_o                 = maddr_ff;
  assign mem_we_o                   = mwe_ff;
  assign mem_lock_o                 = mlock_ff;
  assign mem_wdata_o                = mwdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n || !ce_i);

  sequence s_pde_absent;
    state_ff == ST_DIR_RD && mem_ack_i && !mem_rdata_i[PRESENT_BIT];
  endsequence

  a_lock_on_write: assert property (
    mem_req_o && mem_we_o |-> mem_lock_o)
    else $error("flag write without bus lock");
  a_base_aligned: assert property (
    directory_base_reg_o[OFS_W-1:0] == '0 &&
    directory_base_reg_o[LA_W-1:PA_W] == '0)
    else $error("directory base not aligned or too wide");
  a_fault_addr: assert property (
    fault_o |-> fault_linear_address_reg_o == lin_ff)
    else $error("fault address not captured");
  a_offset_pass: assert property (
    done_o |-> phys_addr_o[OFS_W-1:0] == lin_ff[OFS_W-1:0])
    else $error("page offset altered");
  a_paging_off: assert property (
    state_ff == ST_LOOK && !paging_on
      |=> done_o && phys_addr_o == lin_ff[PA_W-1:0])
    else $error("pass-through address wrong");
  a_dir_index: assert property (
    state_ff == ST_DIR_RD && mem_req_o |-> mem_addr_o ==
      {cr3_ff[PA_W-1:OFS_W], lin_ff[LA_W-1:DIR_IDX_LSB], 2'b00})
    else $error("directory entry address wrong");
  a_tbl_index: assert property (
    state_ff == ST_TBL_RD && mem_req_o |-> mem_addr_o ==
      {pde_ff[PA_W-1:OFS_W], lin_ff[DIR_IDX_LSB-1:TBL_IDX_LSB], 2'b00})
    else $error("table entry address wrong");
  a_flags_written: assert property (
    mem_req_o && mem_we_o |-> mem_wdata_o[ACC_BIT] &&
      (state_ff != ST_TBL_WR || !wr_ff || mem_wdata_o[DIRTY_BIT]))
    else $error("accessed or dirty flag missing");
  a_absent_fault: assert property (
    s_pde_absent |=> fault_o && !fault_code_o[0] ##1 !fault_o)
    else $error("absent entry did not fault");
  a_user_only: assert property (
    fault_o && fault_code_o[0] |-> usr_ff && fault_code_o[2])
    else $error("protection fault at supervisor level");

endmodule // page_translation
`default_nettype wire

/* hdl/paging_pkg.sv */
// Purpose: shared constants and types of the page translation unit
// Assumes: 32-bit linear addresses, 24-bit physical address bus
// Notes:   entry bit positions follow the directory/table entry layout
package paging_pkg;

  // address widths and field positions
  localparam int LA_W        = 32;
  localparam int PA_W        = 24;
  localparam int OFS_W       = 12;
  localparam int VPN_W       = 20;
  localparam int FRAME_W     = PA_W - OFS_W;
  localparam int DIR_IDX_LSB = 22;
  localparam int TBL_IDX_LSB = 12;
  localparam int PAGE_BYTES  = 4096;

  // entry flag positions
  localparam int PRESENT_BIT = 0;
  localparam int RW_BIT      = 1;
  localparam int US_BIT      = 2;
  localparam int ACC_BIT     = 5;
  localparam int DIRTY_BIT   = 6;

  // machine control register paging enable
  localparam int PAGING_BIT  = 31;

  // translation cache geometry
  localparam int TLB_ENTRIES = 32;
  localparam int TLB_WAYS    = 4;

  // values after reset
  localparam logic [LA_W-1:0] FAULT_ADDR_RST = 32'h0000_0000;
  localparam logic [LA_W-1:0] DIR_BASE_RST   = 32'h0000_0000;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_LOOK   = 7'h02,
    ST_DIR_RD = 7'h04,
    ST_DIR_WR = 7'h08,
    ST_TBL_RD = 7'h10,
    ST_TBL_WR = 7'h20,
    ST_FILL   = 7'h40
  } walk_state_e;

endpackage

/* hdl/translation_cache.sv */
// Purpose: set-associative cache of recent page translations
// Assumes: lookup is combinational, fill and flush act at the clock edge
// Notes:   round-robin victim per set; flush beats a fill in the same cycle
`timescale 1ns/100ps
`default_nettype none
module translation_cache
  import paging_pkg::*;
#(
  parameter int ENTRIES = paging_pkg::TLB_ENTRIES,
  parameter int WAYS    = paging_pkg::TLB_WAYS
) (
  // clock and control
  input  wire logic                               clk_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               ce_i,
  // lookup
  input  wire logic [paging_pkg::VPN_W-1:0]       vpn_i,
  output logic                                    hit_o,
  output logic [paging_pkg::FRAME_W-1:0]          hit_frame_o,
  output logic                                    hit_us_o,
  output logic                                    hit_rw_o,
  output logic                                    hit_dirty_o,
  // fill and flush
  input  wire logic                               fill_i,
  input  wire logic [paging_pkg::FRAME_W-1:0]     fill_frame_i,
  input  wire logic                               fill_us_i,
  input  wire logic                               fill_rw_i,
  input  wire logic                               fill_dirty_i,
  input  wire logic                               flush_i
);
  localparam int SETS  = ENTRIES / WAYS;
  localparam int SET_W = $clog2(SETS);
  localparam int WAY_W = $clog2(WAYS);
  localparam int TAG_W = VPN_W - SET_W;
  localparam int DAT_W = FRAME_W + 3;

  if (WAYS < 2 || SETS < 2 || ENTRIES % WAYS != 0 ||
      (1 << SET_W) != SETS || (1 << WAY_W) != WAYS) begin : g_chk
    $error("translation_cache: geometry not supported");
  end

  logic [WAYS-1:0]  vld_ff [SETS];
  logic [TAG_W-1:0] tag_ff [SETS][WAYS];
  logic [DAT_W-1:0] dat_ff [SETS][WAYS];
  logic [WAY_W-1:0] rr_ff  [SETS];

  logic [SET_W-1:0] set;
  logic [TAG_W-1:0] tag;
  logic [WAYS-1:0]  way_hit;
  logic [WAY_W-1:0] hit_way;
  logic [DAT_W-1:0] hit_dat;
  logic [WAY_W-1:0] nxt_way;

  assign set = vpn_i[SET_W-1:0];
  assign tag = vpn_i[VPN_W-1:SET_W];

  for (genvar w = 0; w < WAYS; w++) begin : g_cmp
    assign way_hit[w] = vld_ff[set][w] && (tag_ff[set][w] == tag);
  end

  always_comb begin
    hit_way = '0;
    hit_dat = '0;
    for (int w = 0; w < WAYS; w++) begin
      if (way_hit[w]) begin
        hit_way = WAY_W'(w);
        hit_dat = dat_ff[set][w];
      end
    end
    nxt_way = (|way_hit) ? hit_way : rr_ff[set];
  end

  assign hit_o       = |way_hit;
  assign hit_frame_o = hit_dat[FRAME_W-1:0];
  assign hit_us_o    = hit_dat[FRAME_W];
  assign hit_rw_o    = hit_dat[FRAME_W+1];
  assign hit_dirty_o = hit_dat[FRAME_W+2];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < SETS; s++) begin
        vld_ff[s] <= '0;
        rr_ff[s]  <= '0;
      end
    end else if (ce_i) begin
      if (flush_i) begin
        for (int s = 0; s < SETS; s++) begin
          vld_ff[s] <= '0;
        end
      end else if (fill_i) begin
        vld_ff[set][nxt_way] <= 1'b1;
        tag_ff[set][nxt_way] <= tag;
        dat_ff[set][nxt_way] <= {fill_dirty_i, fill_rw_i, fill_us_i,
                                 fill_frame_i};
        if (!(|way_hit)) begin
          rr_ff[set] <= rr_ff[set] + 1'b1;
        end
      end
    end
  end

  a_flush_empties: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (flush_i && ce_i) |=> !hit_o)
    else $error("cache hit right after flush");

  a_fill_then_hit: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (fill_i && !flush_i && ce_i) ##1 ($stable(vpn_i))
      |-> hit_o && hit_frame_o == $past(fill_frame_i))
    else $error("filled translation not found");

endmodule // translation_cache
`default_nettype wire

/* verification/table_memory.sv */
// Purpose: memory bus partner holding directory and page tables
// Assumes: one 32-bit word per ack, ack one cycle after a request
// Notes:   read data is inverted on every idle cycle
`timescale 1ns/100ps
`default_nettype none
module table_memory (
  // memory bus
  input  wire logic                        clk_i,
  input  wire logic                        req_i,
  input  wire logic [paging_pkg::PA_W-1:0] addr_i,
  input  wire logic                        we_i,
  input  wire logic                        lock_i,
  input  wire logic [paging_pkg::LA_W-1:0] wdata_i,
  output logic      [paging_pkg::LA_W-1:0] rdata_o,
  output logic                             ack_o
);
  import paging_pkg::*;
  logic [LA_W-1:0] mem [logic [PA_W-1:0]];
  int              n_acks = 0;
  int              n_unlocked = 0;
  // counts accesses made without the bus lock
  always @(posedge clk_i) begin
    if (req_i && !ack_o) begin
      ack_o <= 1'b1;
      rdata_o <= mem.exists(addr_i) ? mem[addr_i] : 32'h0;
      if (we_i) mem[addr_i] = wdata_i;
      n_acks++;
      if (!lock_i) n_unlocked++;
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule // table_memory
`default_nettype wire

/* verification/page_translation_tb.sv */
// Purpose: self-checking bench of the page translation unit
// Assumes: table_memory answers every bus request
// Notes:   inputs change on the falling edge
`timescale 1ns/100ps
`default_nettype none
module page_translation_tb;
  import paging_pkg::*;
  logic            clk_i, arst_n_i, req_valid_i, req_write_i, req_user_i;
  logic            cr_write_i, cr_sel_dir_i, task_switch_flush_i, ce_i;
  logic            req_ready_o, done_o, fault_o, mem_req_o, mem_we_o;
  logic            mem_lock_o, mem_ack_i;
  logic [2:0]      fault_code_o;
  logic [PA_W-1:0] phys_addr_o, mem_addr_o, pa;
  logic [LA_W-1:0] req_lin_addr_i, machine_control_reg_i, cr_wdata_i;
  logic [LA_W-1:0] fault_linear_address_reg_o, directory_base_reg_o;
  logic [LA_W-1:0] mem_wdata_o, mem_rdata_i;
  logic            flt;
  int              n_errors = 0, check_count = 0, n0;
  page_translation dut_u (.clk_i, .arst_n_i, .ce_i, .req_valid_i,
    .req_lin_addr_i, .req_write_i, .req_user_i, .req_ready_o, .done_o,
    .phys_addr_o, .fault_o, .fault_code_o, .machine_control_reg_i,
    .cr_write_i, .cr_sel_dir_i, .cr_wdata_i, .task_switch_flush_i,
    .fault_linear_address_reg_o, .directory_base_reg_o, .mem_req_o,
    .mem_addr_o, .mem_we_o, .mem_lock_o, .mem_wdata_o, .mem_rdata_i,
    .mem_ack_i);
  table_memory mem_u (.clk_i, .req_i(mem_req_o), .addr_i(mem_addr_o),
    .we_i(mem_we_o), .lock_i(mem_lock_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [LA_W-1:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cr_wr(input logic dir, input logic [LA_W-1:0] d);
    @(negedge clk_i);
    cr_write_i = 1'b1;
    cr_sel_dir_i = dir;
    cr_wdata_i = d;
    @(negedge clk_i);
    cr_write_i = 1'b0;
  endtask
  task automatic xlate(input logic [LA_W-1:0] la, input logic wr, us);
    int i;
    @(negedge clk_i);
    req_lin_addr_i = la;
    req_write_i = wr;
    req_user_i = us;
    req_valid_i = 1'b1;
    for (i = 0; i < 50 && req_ready_o !== 1'b1; i++) @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (i = 0; i < 50 && done_o !== 1'b1 && fault_o !== 1'b1; i++) begin
      @(negedge clk_i);
    end
    flt = fault_o;
    pa = phys_addr_o;
    if (i == 50) check(32'h0, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    check(directory_base_reg_o, 32'h0);
    cr_wr(1'b1, 32'hab12_3fff);
    check(directory_base_reg_o, 32'h0012_3000);
    ce_i = 1'b0;
    cr_wr(1'b1, 32'h0000_5000);
    check(directory_base_reg_o, 32'h0012_3000);
    ce_i = 1'b1;
    cr_wr(1'b0, 32'h5555_aaaa);
    check(fault_linear_address_reg_o, 32'h5555_aaaa);
    cr_wr(1'b1, 32'h0000_1000);
  endtask
  task automatic s_passthru();
    machine_control_reg_i = 32'h0;
    xlate(32'h1234_5678, 1'b0, 1'b1);
    check({flt, pa}, {1'b0, 24'h34_5678});
    machine_control_reg_i = 32'h8000_0000;
  endtask
  task automatic s_walk_hit();
    n0 = mem_u.n_acks;
    xlate(32'h0040_2abc, 1'b1, 1'b1);
    check({flt, pa}, {1'b0, 24'h05_5abc});
    check(mem_u.mem[24'h00_1004], 32'hff00_2e27);
    check(mem_u.mem[24'h00_2008], 32'h0005_5067);
    check(mem_u.n_unlocked, 0);
    n0 = mem_u.n_acks;
    xlate(32'h0040_2abc, 1'b1, 1'b1);
    check({pa, 1'(mem_u.n_acks == n0)}, {24'h05_5abc, 1'b1});
    @(negedge clk_i);
    task_switch_flush_i = 1'b1;
    @(negedge clk_i);
    task_switch_flush_i = 1'b0;
    xlate(32'h0040_2abc, 1'b0, 1'b1);
    check(mem_u.n_acks > n0, 1);
    n0 = mem_u.n_acks;
    cr_wr(1'b1, 32'h0000_1000);
    xlate(32'h0040_2abc, 1'b0, 1'b1);
    check({pa, 1'(mem_u.n_acks > n0)}, {24'h05_5abc, 1'b1});
  endtask
  task automatic s_faults();
    xlate(32'h0080_3123, 1'b1, 1'b1);
    check({flt, fault_code_o}, 4'he);
    check(fault_linear_address_reg_o, 32'h0080_3123);
    xlate(32'h0040_4010, 1'b1, 1'b1);
    check({flt, fault_code_o}, 4'hf);
    check(fault_linear_address_reg_o, 32'h0040_4010);
    xlate(32'h0040_4010, 1'b0, 1'b1);
    check({flt, pa}, {1'b0, 24'h07_7010});
    xlate(32'h0040_4010, 1'b1, 1'b0);
    check({flt, pa}, {1'b0, 24'h07_7010});
    n0 = mem_u.n_acks;
    xlate(32'h0040_4010, 1'b1, 1'b1);
    check({flt, fault_code_o, 1'(mem_u.n_acks == n0)}, 5'h1f);
    xlate(32'h0040_0000, 1'b0, 1'b1);
    check({flt, fault_code_o}, 4'hc);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #(40 * 20000);
    n_errors++;
    report_and_stop();
  end
  initial begin
    {arst_n_i, req_valid_i, req_write_i, req_user_i} = 4'h0;
    {cr_write_i, cr_sel_dir_i, task_switch_flush_i} = 3'h0;
    ce_i = 1'b1;
    {req_lin_addr_i, machine_control_reg_i, cr_wdata_i} = 96'h0;
    // tables written only while no walk holds the bus
    mem_u.mem[24'h00_1004] = 32'hff00_2e07;
    mem_u.mem[24'h00_1008] = 32'h0000_0e06;
    mem_u.mem[24'h00_2008] = 32'h0005_5007;
    mem_u.mem[24'h00_2010] = 32'h0007_7005;
    repeat (20) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    s_regs();
    s_passthru();
    s_walk_hit();
    s_faults();
    report_and_stop();
  end
endmodule // page_translation_tb
`default_nettype wire
